//--- rtl/bud_counter.sv
// single bcd up/down counter digit with load, clear and cascade carry
//
// Notes on behaviour
// - load strobe high copies load inputs through
// - load strobe high blocks counting
// - clear forces zero, beats load
// - direction high counts up, low down
// - count state moves only on rising edges that reset, count, clear or load
// - cascade enable high holds the count
// - count bits in bcd, bit0 least
// - ten enabled edges make one decade
// - up terminal: bit0, bit3 high, enable low
// - down terminal: all zero, enable low
// - terminal count active low, decoded from the shown count
// - terminal count low one full cycle
// - counting resumes from loaded value
`include "bud_defines.svh"

module bud_counter (
  input  wire logic        clk_sys,      // system clock, 100 MHz
  input  wire logic        srst,         // synchronous reset, active high
  input  wire logic        clear,        // transparent clear, active high
  input  wire logic        load_strobe,  // transparent load, active high
  input  wire logic        load_bit0,    // load value, least significant
  input  wire logic        load_bit1,    // load value bit 1
  input  wire logic        load_bit2,    // load value bit 2
  input  wire logic        load_bit3,    // load value, most significant
  input  wire logic        dir_up,       // high counts up, low down
  input  wire logic        carry_in_n,   // cascade enable, active low
  output logic             count_bit0,   // count, least significant
  output logic             count_bit1,   // count bit 1
  output logic             count_bit2,   // count bit 2
  output logic             count_bit3,   // count, most significant
  output logic             carry_out_n,  // terminal count, active low
  output logic             non_bcd,      // shown code is above nine
  output logic             digit_wrap,   // one-cycle pulse after a wrap
  output bud_pkg::bud_mode_t op_mode     // action of the last edge
);
  import bud_pkg::*;

  bud_digit_t count_reg;
  bud_digit_t count_next;
  bud_digit_t load_val;
  bud_digit_t count_shown;
  logic       count_en;
  logic       step_wrap;
  logic       tc_up;
  logic       tc_down;
  logic       wrap_reg;
  bud_mode_t  mode_reg;
  bud_mode_t  mode_next;

  // gather the loose load pins into one digit
  assign load_val = {load_bit3, load_bit2, load_bit1, load_bit0};

  // cascade enable high blocks the step
  assign count_en = ~clear & ~load_strobe & ~carry_in_n;

  // one step of the digit in the chosen direction
  // direction selects step
  bud_step u_step (
    .cur  (count_reg),
    .nxt  (count_next),
    .up   (dir_up),
    .wrap (step_wrap)
  );

  // count state; clear and load also land in the register so that
  // the digit keeps the forced value once the strobe falls
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_reg <= `BUD_RESET_COUNT;
    end else if (clear) begin
      count_reg <= `BUD_RESET_COUNT;
    end else if (load_strobe) begin
      count_reg <= load_val;
    end else if (count_en) begin
      count_reg <= count_next;
    end
  end

  // transparent path: clear and load show at once, without a clock edge,
  // since the pins act on the outputs as soon as they change; the price
  // is that the count outputs are not purely registered while forced
  always_comb begin
    if (clear) begin
      count_shown = `BUD_RESET_COUNT;
    end else if (load_strobe) begin
      count_shown = load_val;
    end else begin
      count_shown = count_reg;
    end
  end

  assign count_bit0 = count_shown[0];
  assign count_bit1 = count_shown[1];
  assign count_bit2 = count_shown[2];
  assign count_bit3 = count_shown[3];

  // codes ten to fifteen only arise from a bad load value
  assign non_bcd = (count_shown > `BUD_DIGIT_MAX);

  // up terminal decode
  // only bits 0 and 3 are looked at, as in a plain decade decode
  assign tc_up = dir_up & count_shown[`BUD_TC_LSB_POS]
                 & count_shown[`BUD_TC_MSB_POS] & ~carry_in_n;

  assign tc_down = ~dir_up & (count_shown == `BUD_DIGIT_MIN) & ~carry_in_n;

  // low while the digit sits at its end, one enabled cycle
  // a neighbour stage may take this as its cascade enable
  assign carry_out_n = ~(tc_up | tc_down);

  // wrap pulse: marks the edge on which the decade rolled over
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wrap_reg <= 1'b0;
    end else begin
      wrap_reg <= count_en & step_wrap;
    end
  end

  assign digit_wrap = wrap_reg;

  // classify what the coming edge does, in the same priority as the count
  always_comb begin
    if (clear) begin
      mode_next = BUD_MODE_CLEAR;
    end else if (load_strobe) begin
      mode_next = BUD_MODE_LOAD;
    end else if (!count_en) begin
      mode_next = BUD_MODE_HOLD;
    end else if (dir_up) begin
      mode_next = BUD_MODE_UP;
    end else begin
      mode_next = BUD_MODE_DOWN;
    end
  end

  // last action, kept for observation by the surrounding logic
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_reg <= BUD_MODE_HOLD;
    end else begin
      mode_reg <= mode_next;
    end
  end

  assign op_mode = mode_reg;

endmodule

//--- rtl/bud_defines.svh
// constants for the bcd up/down counter digit
`ifndef BUD_DEFINES_SVH
`define BUD_DEFINES_SVH

// width of one bcd digit
`define BUD_DIGIT_W     4
// count value after synchronous reset or clear
`define BUD_RESET_COUNT 4'h0
// top of the decade, terminal count when counting up
`define BUD_DIGIT_MAX   4'h9
// bottom of the decade, terminal count when counting down
`define BUD_DIGIT_MIN   4'h0
// bit positions decoded for the up terminal count
`define BUD_TC_LSB_POS  0
`define BUD_TC_MSB_POS  3

`endif

//--- rtl/bud_pkg.sv
// types shared by the bcd up/down counter digit
`include "bud_defines.svh"

package bud_pkg;

  // one bcd digit
  typedef logic [`BUD_DIGIT_W-1:0] bud_digit_t;

  // what the digit did on the last clock edge
  typedef enum logic [2:0] {
    BUD_MODE_HOLD,
    BUD_MODE_UP,
    BUD_MODE_DOWN,
    BUD_MODE_LOAD,
    BUD_MODE_CLEAR
  } bud_mode_t;

endpackage

//--- rtl/bud_step.sv
// next value of a bcd digit for one step up or down
`include "bud_defines.svh"

module bud_step (
  input  bud_pkg::bud_digit_t cur,   // present digit
  input  wire logic           up,    // high to step up, low to step down
  output bud_pkg::bud_digit_t nxt,   // digit after one step
  output logic                wrap   // step crosses the decade boundary
);
  import bud_pkg::*;

  // wrap at decade ends
  // codes above nine fold back into the decade in one step either way
  always_comb begin
    nxt  = cur;
    wrap = 1'b0;
    if (up) begin
      if (cur >= `BUD_DIGIT_MAX) begin
        nxt  = `BUD_DIGIT_MIN;
        wrap = 1'b1;
      end else begin
        nxt = cur + 4'h1;
      end
    end else begin
      if (cur == `BUD_DIGIT_MIN || cur > `BUD_DIGIT_MAX) begin
        nxt  = `BUD_DIGIT_MAX;
        wrap = 1'b1;
      end else begin
        nxt = cur - 4'h1;
      end
    end
  end

endmodule

//--- tb/bud_sva.sv
// checker for one bcd digit: clear, load, counting, terminal count
module bud_sva (
  input wire logic clk_sys, srst, clear, load_strobe, dir_up, carry_in_n,
  input wire logic load_bit0, load_bit1, load_bit2, load_bit3,
  input wire logic count_bit0, count_bit1, count_bit2, count_bit3,
  input wire logic carry_out_n
);
  logic [3:0] q;
  logic [3:0] ld;
  // shown count and load value as vectors
  assign q = {count_bit3, count_bit2, count_bit1, count_bit0};
  assign ld = {load_bit3, load_bit2, load_bit1, load_bit0};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // an enabled edge, then an edge with no bypass active
  sequence s_run; !clear && !load_strobe && !carry_in_n; endsequence
  sequence s_free; !clear && !load_strobe; endsequence
  property p_clr; clear |-> q == 4'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_load; load_strobe && !clear |-> q == ld; endproperty
  a_load: assert property (p_load) else $error("load");
  property p_resume; load_strobe && !clear ##1 s_free |-> q == $past(ld);
  endproperty
  a_resume: assert property (p_resume) else $error("resume");
  property p_up; s_run ##0 dir_up && q < 4'h9 ##1 s_free
    |-> q == $past(q) + 4'h1; endproperty
  a_up: assert property (p_up) else $error("up step");
  property p_wrap; s_run ##0 dir_up && q == 4'h9 ##1 s_free |-> q == 4'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap");
  property p_hold; carry_in_n ##0 s_free ##1 s_free |-> $stable(q);
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_tcu; dir_up |-> carry_out_n ==
    !(count_bit0 && count_bit3 && !carry_in_n); endproperty
  a_tcu: assert property (p_tcu) else $error("up carry");
  property p_tcd; !dir_up |-> carry_out_n == !(q == 4'h0 && !carry_in_n);
  endproperty
  a_tcd: assert property (p_tcd) else $error("down carry");
endmodule
bind bud_counter bud_sva u_sva (.*);

//--- tb/bud_next_stage.sv
// upper digit model clocked in parallel with the digit under test
module bud_next_stage (
  input  wire logic  clk_sys, // shared clock
  input  wire logic  srst,    // synchronous reset
  input  wire logic  carry_n, // lower digit terminal count
  input  wire logic  dir_up,  // shared direction
  output logic [3:0] digit    // upper digit
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk_sys) begin
    if (srst) digit <= 4'h0;
    else if (!carry_n && dir_up)
      digit <= (digit == 4'h9) ? 4'h0 : digit + 4'h1;
    else if (!carry_n)
      digit <= (digit == 4'h0) ? 4'h9 : digit - 4'h1;
  end
endmodule

//--- tb/testbench.sv
// bench for one bcd digit with a chained upper digit
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import bud_pkg::*;
  logic       clk_sys = 0, srst = 1, clear = 0, load_strobe = 0;
  logic       dir_up = 1, carry_in_n = 0, carry_out_n, non_bcd, wrap;
  logic [3:0] ld = 4'h0, q, tens;
  bud_mode_t  op_mode;
  int         mismatches = 0, comparisons = 0;
  // free clock, 10 ns period
  always #5 clk_sys = ~clk_sys;
  bud_counter dut (.clk_sys, .srst, .clear, .load_strobe, .dir_up,
    .load_bit0(ld[0]), .load_bit1(ld[1]), .load_bit2(ld[2]),
    .load_bit3(ld[3]), .carry_in_n, .count_bit0(q[0]), .count_bit1(q[1]),
    .count_bit2(q[2]), .count_bit3(q[3]), .carry_out_n, .non_bcd,
    .digit_wrap(wrap), .op_mode);
  bud_next_stage nxt (.clk_sys, .srst, .carry_n(carry_out_n), .dir_up,
    .digit(tens));
  task automatic check(input logic [3:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // wait n edges, then let their updates settle
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_up;
    tick(9);
    check(q, 4'h9);
    check({3'h0, carry_out_n}, 4'h0);
    tick(1);
    check(q, 4'h0);
    check(tens, 4'h1);
    check({3'h0, carry_out_n}, 4'h1);
    check({3'h0, wrap}, 4'h1);
    check({1'b0, op_mode}, {1'b0, BUD_MODE_UP});
  endtask
  // clear during load forces zero; the reload then counts down to zero and drives the down carry low
  task automatic t_load;
    @(posedge clk_sys);
    {load_strobe, dir_up, ld} <= {2'b10, 4'h3};
    #1 check(q, 4'h3);
    tick(2);
    check(q, 4'h3);
    @(posedge clk_sys);
    clear <= 1'b1;
    #1 check(q, 4'h0);
    @(posedge clk_sys);
    clear <= 1'b0;
    @(posedge clk_sys);
    load_strobe <= 1'b0;
    tick(3);
    check(q, 4'h0);
    check({3'h0, carry_out_n}, 4'h0);
    tick(1);
    check(q, 4'h9);
    check(tens, 4'h9);
  endtask
  task automatic t_hold;
    @(posedge clk_sys);
    carry_in_n <= 1'b1;
    tick(3);
    check(q, 4'h8);
    check({3'h0, carry_out_n}, 4'h1);
  endtask
  // divider use: nonzero ratio loaded, counting down, then a bad code
  task automatic t_div;
    @(posedge clk_sys);
    {load_strobe, carry_in_n, ld} <= {2'b10, 4'h2};
    tick(1);
    check({1'b0, op_mode}, {1'b0, BUD_MODE_LOAD});
    @(posedge clk_sys);
    load_strobe <= 1'b0;
    tick(2);
    check(q, 4'h0);
    check({3'h0, carry_out_n}, 4'h0);
    tick(1);
    check(q, 4'h9);
    check({3'h0, wrap}, 4'h1);
    check({1'b0, op_mode}, {1'b0, BUD_MODE_DOWN});
    @(posedge clk_sys);
    {load_strobe, ld} <= {1'b1, 4'hc};
    #1 check({3'h0, non_bcd}, 4'h1);
    @(posedge clk_sys);
    load_strobe <= 1'b0;
    tick(1);
    check(q, 4'h9);
  endtask
  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // main sequence after a 12-cycle reset
  initial begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    t_up;
    t_load;
    t_hold;
    t_div;
    print_verdict;
  end
  // watchdog, far beyond the expected 45 cycles
  initial begin
    #3000;
    mismatches++;
    print_verdict;
  end
endmodule
